// *** logic/code_option_decoder.sv ***
// Purpose: Latches the code option word and turns it into static controls and clock enables.
// Assumes: All inputs synchronous to clk_sys, which is the fast oscillator.
// Notes: Registers on APB with zero wait states; read of status clears it.
`timescale 1ns/1ps
`include "code_option_defs.svh"
module code_option_decoder #(
  parameter int OPT_W = 16
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic [OPT_W-1:0]              option_word,
  input  wire code_option_pkg::power_mode_t  power_mode,
  input  wire logic                          losc_tick,
  input  wire logic                          wdt_overflow,
  input  wire logic                          below_1v8,
  input  wire logic                          below_2v3,
  input  wire logic                          below_3v0,
  input  wire logic                          pin_in,
  output logic                               pin_out,
  output logic                               pin_oe_n,
  input  wire code_option_pkg::apb_req_t     apb_req,
  output code_option_pkg::apb_rsp_t          apb_rsp,
  output logic                               wdt_tick,
  output logic                               wdt_reset,
  output logic                               ext_reset,
  output logic                               powerup_hold,
  output logic                               brownout_reset,
  output logic                               supply_below_mid_flag,
  output logic                               supply_below_high_flag,
  output logic                               fcpu_tick,
  output logic                               readout_protect,
  output logic                               noise_filter_en,
  output logic                               irq
);

  if (OPT_W < `OPT_MIN_WIDTH) begin : g_narrow
    $error("option word too narrow");
  end

  code_option_pkg::option_t opt_q;
  logic                     opt_ok_q;
  logic [4:0]               wdt_cnt_q;
  logic [6:0]               hi_cnt_q;
  logic [2:0]               lo_cnt_q;
  logic [2:0]               samp_q;
  logic [2:0]               filt_q;
  logic [2:0]               below_v;
  logic                     pin_q;
  logic                     pin_seen_q;
  logic [`EV_W-1:0]         status_q;
  logic [`EV_W-1:0]         mask_q;
  logic [1:0]               port_q;
  logic [`EV_W-1:0]         ev;
  logic [4:0]               wdt_term;
  logic [6:0]               hi_term;
  logic [2:0]               lo_term;
  logic                     wdt_run;
  logic                     bor_d;
  logic                     mid_d;
  logic                     high_d;
  logic                     acc;
  logic                     rd_status;

  // Options are caught once on the first edge after release, never from the reset branch.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opt_q    <= '0;
      opt_ok_q <= 1'b0;
    end else if (!opt_ok_q) begin
      opt_ok_q <= 1'b1; // RULE_17
      opt_q.watchdog_clock_select <= option_word[`OPT_WDT_SRC_LSB +: 2];
      opt_q.wdt_mode     <= code_option_pkg::wdt_mode_t'(option_word[`OPT_WDT_MODE_LSB +: 2]);
      opt_q.shared_port_bit_mode <= option_word[`OPT_RST_PIN_BIT];
      opt_q.secure       <= option_word[`OPT_SECURE_BIT];
      opt_q.lvd_level    <= code_option_pkg::lvd_level_t'(option_word[`OPT_LVD_LSB +: 2]);
      opt_q.hi_fcpu      <= option_word[`OPT_HI_FCPU_LSB +: 3];
      opt_q.lo_fcpu      <= option_word[`OPT_LO_FCPU_LSB +: 2];
      opt_q.noise_filter <= option_word[`OPT_NOISE_BIT];
    end
  end

  // Divider terminals; the reserved clock code behaves as the slowest choice.
  always_comb begin
    case (opt_q.watchdog_clock_select)
      2'h0:    wdt_term = 5'(`WDT_DIV_BASE - 6'h01); // RULE_01
      2'h1:    wdt_term = 5'((`WDT_DIV_BASE << 1) - 6'h01);
      default: wdt_term = 5'((`WDT_DIV_BASE << 2) - 6'h01);
    endcase
    hi_term = 7'((8'h01 << opt_q.hi_fcpu) - 8'h01); // RULE_12
    lo_term = 3'((4'h1 << opt_q.lo_fcpu) - 4'h1); // RULE_13
  end

  // Counting stops in sleep and green only for the plain enable setting.
  always_comb begin
    case (opt_q.wdt_mode)
      code_option_pkg::WDT_ALWAYS: wdt_run = opt_ok_q; // RULE_02
      code_option_pkg::WDT_ON: wdt_run = opt_ok_q &&
        (power_mode == code_option_pkg::MODE_NORMAL ||
         power_mode == code_option_pkg::MODE_SLOW); // RULE_03
      default: wdt_run = 1'b0; // RULE_04
    endcase
  end

  // Watchdog clock divider on the slow oscillator tick.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt_q <= 5'h00;
      wdt_tick  <= 1'b0;
    end else begin
      wdt_tick <= wdt_run && losc_tick && (wdt_cnt_q == wdt_term);
      if (!wdt_run) begin
        wdt_cnt_q <= 5'h00;
      end else if (losc_tick) begin
        wdt_cnt_q <= (wdt_cnt_q == wdt_term) ? 5'h00 : wdt_cnt_q + 5'h01;
      end
    end
  end

  // An overflow only becomes a reset while the watchdog is not disabled.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdt_reset <= 1'b0;
    end else begin
      wdt_reset <= wdt_overflow && opt_ok_q &&
                   (opt_q.wdt_mode == code_option_pkg::WDT_ON ||
                    opt_q.wdt_mode == code_option_pkg::WDT_ALWAYS); // RULE_04
    end
  end

  // Instruction cycle enable: fast clock in normal, slow tick in slow, none when stopped.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_q  <= 7'h00;
      lo_cnt_q  <= 3'h0;
      fcpu_tick <= 1'b0;
    end else begin
      fcpu_tick <= 1'b0;
      if (power_mode == code_option_pkg::MODE_NORMAL && opt_ok_q) begin
        hi_cnt_q  <= (hi_cnt_q == hi_term) ? 7'h00 : hi_cnt_q + 7'h01;
        fcpu_tick <= (hi_cnt_q == hi_term); // RULE_12
      end else begin
        hi_cnt_q <= 7'h00;
      end
      if (power_mode == code_option_pkg::MODE_SLOW && opt_ok_q) begin
        if (losc_tick) begin
          lo_cnt_q  <= (lo_cnt_q == lo_term) ? 3'h0 : lo_cnt_q + 3'h1;
          fcpu_tick <= (lo_cnt_q == lo_term); // RULE_13
        end
      end else begin
        lo_cnt_q <= 3'h0;
      end
    end
  end

  assign below_v = {below_3v0, below_2v3, below_1v8}; // Comparators as one indexable vector.
  // With filtering on, a level passes only after two equal samples; this adds no cycle, as both paths go through samp_q.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      samp_q <= 3'h0;
      filt_q <= 3'h0;
    end else begin
      samp_q <= below_v;
      for (int i = 0; i < 3; i++) begin
        if (!opt_q.noise_filter || (samp_q[i] == below_v[i])) begin
          filt_q[i] <= samp_q[i]; // RULE_14
        end
      end
    end
  end

  // Brown-out reset threshold and flag enables by level.
  always_comb begin
    bor_d  = filt_q[0]; // RULE_08
    mid_d  = 1'b0;
    high_d = 1'b0;
    case (opt_q.lvd_level)
      code_option_pkg::LVD_MIDDLE:  mid_d = filt_q[1]; // RULE_09
      code_option_pkg::LVD_HIGH: begin
        bor_d  = filt_q[1]; // RULE_10
        high_d = filt_q[2];
      end
      code_option_pkg::LVD_MAXIMUM: bor_d = filt_q[2]; // RULE_11
      default: bor_d = filt_q[0];
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      brownout_reset         <= 1'b0;
      supply_below_mid_flag  <= 1'b0;
      supply_below_high_flag <= 1'b0;
    end else begin
      brownout_reset         <= opt_ok_q && bor_d;
      supply_below_mid_flag  <= opt_ok_q && mid_d; // RULE_16
      supply_below_high_flag <= opt_ok_q && high_d; // RULE_16
    end
  end

  // Shared pin: reset input or port bit; drive enable is active low.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_q        <= 1'b1;
      pin_seen_q   <= 1'b0;
      ext_reset    <= 1'b0;
      powerup_hold <= 1'b1;
    end else begin
      pin_q     <= pin_in;
      ext_reset <= opt_ok_q && opt_q.shared_port_bit_mode && pin_q && !pin_in; // RULE_05
      if (opt_ok_q && (pin_in || !opt_q.shared_port_bit_mode)) begin
        pin_seen_q <= 1'b1;
      end
      powerup_hold <= !(pin_seen_q || (opt_ok_q && (pin_in || !opt_q.shared_port_bit_mode))); // RULE_15
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out  <= port_q[0];
      pin_oe_n <= !(opt_ok_q && !opt_q.shared_port_bit_mode && port_q[1]); // RULE_06
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      readout_protect <= 1'b1;
      noise_filter_en <= 1'b0;
    end else begin
      readout_protect <= !opt_ok_q || opt_q.secure; // RULE_07
      noise_filter_en <= opt_ok_q && opt_q.noise_filter; // RULE_14
    end
  end

  // Events for the sticky status register.
  assign ev[`EV_EXT]  = ext_reset;
  assign ev[`EV_BOR]  = brownout_reset;
  assign ev[`EV_MID]  = supply_below_mid_flag;
  assign ev[`EV_HIGH] = supply_below_high_flag;
  assign ev[`EV_WDT]  = wdt_reset;

  // APB access phase; no wait states are ever inserted.
  assign acc       = apb_req.psel && apb_req.penable;
  assign rd_status = acc && !apb_req.pwrite && (apb_req.paddr == `REG_STATUS);

  // A new event in the clearing read is kept, so the set wins.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      status_q <= (rd_status ? '0 : status_q) | ev;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= `MASK_RESET;
      port_q <= `PORT_RESET;
    end else if (acc && apb_req.pwrite) begin
      if (apb_req.paddr == `REG_MASK) begin
        mask_q <= apb_req.pwdata[`EV_W-1:0];
      end
      if (apb_req.paddr == `REG_PORT) begin
        port_q <= apb_req.pwdata[1:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero with an error flag.
  always_comb begin
    apb_rsp.prdata  = 32'h0000_0000;
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = 1'b0;
    case (apb_req.paddr)
      `REG_OPTION: apb_rsp.prdata = {18'h0_0000, opt_q};
      `REG_STATUS: apb_rsp.prdata = {27'h000_0000, status_q};
      `REG_MASK:   apb_rsp.prdata = {27'h000_0000, mask_q};
      `REG_PORT:   apb_rsp.prdata = {29'h000_0000, pin_in, port_q};
      `REG_FLAGS:  apb_rsp.prdata = {28'h000_0000, supply_below_high_flag,
                                     supply_below_mid_flag, brownout_reset, powerup_hold};
      default:     apb_rsp.pslverr = apb_req.psel;
    endcase
  end

  assign irq = |(status_q & mask_q);

  // Checks that sit beside the logic they guard.
  sequence s_pin_fall;
    pin_q && !pin_in;
  endsequence
  sequence s_reset_pulse;
    ext_reset ##1 !ext_reset;
  endsequence

  AST_WDT_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
    opt_q.wdt_mode == code_option_pkg::WDT_OFF |=> !wdt_tick && !wdt_reset)
    else $error("disabled watchdog ticked or reset");
  AST_WDT_HALT: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_03
    opt_q.wdt_mode == code_option_pkg::WDT_ON && power_mode == code_option_pkg::MODE_SLEEP
    |=> !wdt_tick)
    else $error("enabled watchdog ticked in sleep");
  AST_WDT_ALWAYS: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    opt_ok_q && opt_q.wdt_mode == code_option_pkg::WDT_ALWAYS && losc_tick &&
    wdt_cnt_q == wdt_term |=> wdt_tick)
    else $error("always-on watchdog missed a tick");
  AST_EXT_RST: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
    (opt_ok_q && opt_q.shared_port_bit_mode) and s_pin_fall |=> s_reset_pulse)
    else $error("pin fall did not give one reset pulse");
  AST_PORT_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
    !opt_q.shared_port_bit_mode |=> !ext_reset)
    else $error("reset from pin in port mode");
  AST_PROTECT: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
    opt_ok_q |=> readout_protect == $past(opt_q.secure))
    else $error("protection does not follow option");
  AST_BOR_MAX: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    opt_ok_q && opt_q.lvd_level == code_option_pkg::LVD_MAXIMUM && below_3v0 [*3]
    |-> ##[1:2] brownout_reset)
    else $error("no reset below top threshold");
  AST_MID_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_09
    opt_ok_q && opt_q.lvd_level == code_option_pkg::LVD_MIDDLE && below_2v3 [*3]
    |-> ##[1:2] supply_below_mid_flag)
    else $error("mid flag not set below level");
  AST_FCPU_DIV1: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_12
    opt_ok_q && opt_q.hi_fcpu == 3'h0 && power_mode == code_option_pkg::MODE_NORMAL
    |=> fcpu_tick)
    else $error("undivided cycle enable missing");
  AST_LATCH: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_17
    opt_ok_q |=> $stable(opt_q) && opt_ok_q)
    else $error("options changed after latch");
  AST_IRQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ev & mask_q) != '0 ##1 $stable(mask_q) |-> irq)
    else $error("unmasked event did not raise the interrupt");

endmodule

// *** pkg/code_option_defs.svh ***
// Purpose: Offsets, field positions, reset values and divider figures of the option decoder.
// Assumes: Included by its bare name; definitions only.
// Notes: Behaviour list follows.
// Behaviour
// (RULE_01) Watchdog clock is slow oscillator over 8/16/32.
// (RULE_02) Always-on watchdog counts in sleep and green.
// (RULE_03) Enabled watchdog halts in sleep and green.
// (RULE_04) Disabled watchdog never counts nor resets.
// (RULE_05) Reset pin falling edge resets the system.
// (RULE_06) Port mode disables reset, pin is port.
// (RULE_07) Read-out protection blocks full flash dump.
// (RULE_08) Lowest level resets below 1.8V.
// (RULE_09) Middle level enables the 2.3V flag.
// (RULE_10) High level resets below 2.3V, 3.0V flag.
// (RULE_11) Maximum level resets below 3.0V.
// (RULE_12) Normal cycle is fast clock over 1..128.
// (RULE_13) Slow cycle is slow clock over 1..8.
// (RULE_14) Noise filter smooths supply inputs when enabled.
// (RULE_15) Reset pin held low keeps power-up reset.
// (RULE_16) Enabled flag is 1 below level, else 0.
// (RULE_17) Options latched at reset, constant until reset.
`ifndef CODE_OPTION_DEFS_SVH
`define CODE_OPTION_DEFS_SVH
`define OPT_WDT_SRC_LSB   0
`define OPT_WDT_MODE_LSB  2
`define OPT_RST_PIN_BIT   4
`define OPT_SECURE_BIT    5
`define OPT_LVD_LSB       6
`define OPT_HI_FCPU_LSB   8
`define OPT_LO_FCPU_LSB   11
`define OPT_NOISE_BIT     13
`define OPT_MIN_WIDTH     14
`define WDT_DIV_BASE      6'h08
`define REG_OPTION        12'h000
`define REG_STATUS        12'h004
`define REG_MASK          12'h008
`define REG_PORT          12'h00C
`define REG_FLAGS         12'h010
`define MASK_RESET        5'h00
`define PORT_RESET        2'h0
`define EV_EXT            0
`define EV_BOR            1
`define EV_MID            2
`define EV_HIGH           3
`define EV_WDT            4
`define EV_W              5
`endif

// *** pkg/code_option_pkg.sv ***
// Purpose: Types shared by the option decoder and its users.
// Assumes: Nothing is imported; users write code_option_pkg::name.
// Notes: Field meanings are in the defs header.
package code_option_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_SLOW, MODE_GREEN, MODE_SLEEP} power_mode_t;
  typedef enum logic [1:0] {WDT_OFF, WDT_ON, WDT_ALWAYS, WDT_RSVD} wdt_mode_t;
  typedef enum logic [1:0] {LVD_LOWEST, LVD_MIDDLE, LVD_HIGH, LVD_MAXIMUM} lvd_level_t;
  typedef struct packed {
    logic [1:0]  watchdog_clock_select;
    wdt_mode_t   wdt_mode;
    logic        shared_port_bit_mode;
    logic        secure;
    lvd_level_t  lvd_level;
    logic [2:0]  hi_fcpu;
    logic [1:0]  lo_fcpu;
    logic        noise_filter;
  } option_t;
  typedef struct packed {
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;
endpackage

// *** sim/code_option_decoder_tb.sv ***
// Purpose: Self-checking bench for the code option decoder, driving every port directly.
// Assumes: Zero-wait APB slave; the slow oscillator tick is made here every fourth clock.
// Notes: Options latch only at reset, so each option code is booted in turn.
`timescale 1ns/1ps
`include "code_option_defs.svh"
module code_option_decoder_tb;
  logic                         clk_sys = 1'b0;
  logic                         rst_n = 1'b0;
  logic [15:0]                  option_word = 16'h0000;
  code_option_pkg::power_mode_t power_mode = code_option_pkg::MODE_NORMAL;
  logic                         losc_tick = 1'b0;
  logic [1:0]                   losc_cnt = 2'h0;
  logic                         wdt_overflow = 1'b0;
  logic [2:0]                   below = 3'h0;
  logic                         pin_in = 1'b0;
  code_option_pkg::apb_req_t    apb_req = '0;
  code_option_pkg::apb_rsp_t    apb_rsp;
  logic                         pin_out, pin_oe_n, wdt_tick, wdt_reset, ext_reset;
  logic                         powerup_hold, brownout_reset, mid_f, high_f, fcpu_tick;
  logic                         readout_protect, noise_filter_en, irq, er;
  logic [31:0]                  rd;
  logic [15:0]                  w;
  logic [1:0]                   lv, wc;
  int                           fail_count = 0, checks_done = 0, n, ef, ew;

  // Free-running clock at 100 MHz.
  always #5 clk_sys = ~clk_sys;

  // Slow oscillator tick every fourth clock, so every divider period divides a 256-cycle window.
  always @(posedge clk_sys) begin
    losc_cnt <= losc_cnt + 2'h1;
    losc_tick <= (losc_cnt == 2'h3);
  end

  code_option_decoder #(.OPT_W(16)) code_option_decoder_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .option_word(option_word), .power_mode(power_mode),
    .losc_tick(losc_tick), .wdt_overflow(wdt_overflow), .below_1v8(below[0]),
    .below_2v3(below[1]), .below_3v0(below[2]), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .wdt_tick(wdt_tick),
    .wdt_reset(wdt_reset), .ext_reset(ext_reset), .powerup_hold(powerup_hold),
    .brownout_reset(brownout_reset), .supply_below_mid_flag(mid_f),
    .supply_below_high_flag(high_f), .fcpu_tick(fcpu_tick),
    .readout_protect(readout_protect), .noise_filter_en(noise_filter_en), .irq(irq));

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compares one value; case inequality so an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits an edge first so psel is never lowered and raised in one step.
  task automatic apb(input logic [11:0] a, input logic wr_en, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int t;
    @(posedge clk_sys);
    apb_req.paddr <= a;
    apb_req.pwrite <= wr_en;
    apb_req.pwdata <= d;
    apb_req.psel <= 1'b1;
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (apb_rsp.pready !== 1'b1 && t < 20);
    if (apb_rsp.pready !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  // Selects one pulse output by index, for counting.
  function automatic logic pick(input int s);
    case (s)
      0: pick = fcpu_tick;
      1: pick = wdt_tick;
      2: pick = ext_reset;
      default: pick = wdt_reset;
    endcase
  endfunction

  task automatic count(input int s, input int cycles, output int c);
    c = 0;
    repeat (cycles) begin
      @(posedge clk_sys);
      if (pick(s) === 1'b1) c++;
    end
  endtask

  // Resets for six cycles with a new option word; the pin is held low through power-up.
  task automatic boot(input logic [15:0] ow);
    rst_n <= 1'b0;
    option_word <= ow;
    pin_in <= 1'b0;
    below <= 3'h0;
    power_mode <= code_option_pkg::MODE_NORMAL;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  // Hang guard: a run that overstays counts as a mismatch.
  initial begin
    #1000000;
    fail_count++;
    report_and_stop();
  end

  // Every code of every field is booted at least once across the eight passes.
  initial begin
    for (int k = 0; k < 8; k++) begin
      w = {2'b00, ~k[0], k[1:0], k[2:0], k[1:0], k[2], k[1] ^ k[0], k[1:0], k[1:0]};
      lv = w[7:6];
      wc = (w[1:0] == 2'h3) ? 2'h2 : w[1:0];
      boot(w);
      option_word <= ~w;
      apb(`REG_OPTION, 1'b0, 32'h0, rd, er);
      chk(rd, {18'h0, w[1:0], w[3:2], w[4], w[5], w[7:6], w[10:8], w[12:11], w[13]});
      chk(readout_protect, w[5]);
      chk(noise_filter_en, w[13]);
      chk(powerup_hold, w[4]);
      pin_in <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(powerup_hold, 32'h0);
      apb(`REG_STATUS, 1'b0, 32'h0, rd, er);
      pin_in <= 1'b0;
      count(2, 4, n);
      chk(n != 0, w[4]);
      chk(irq, 32'h0);
      apb(`REG_MASK, 1'b1, 32'h1, rd, er);
      apb(`REG_MASK, 1'b0, 32'h0, rd, er);
      chk(rd, 32'h1);
      chk(irq, w[4]);
      apb(`REG_STATUS, 1'b0, 32'h0, rd, er);
      chk(rd[0], w[4]);
      @(posedge clk_sys);
      chk(irq, 32'h0);
      // After a write to the unmapped word, its read must return zero in bits 30:0 with the error flag set.
      apb(12'h020, 1'b1, 32'hFFFFFFFF, rd, er);
      apb(12'h020, 1'b0, 32'h0, rd, er);
      chk({rd[30:0], er}, 32'h1);
      apb(`REG_PORT, 1'b1, 32'h3, rd, er);
      repeat (2) @(posedge clk_sys);
      chk({pin_oe_n, pin_out}, {w[4], 1'b1});
      apb(`REG_PORT, 1'b0, 32'h0, rd, er);
      chk(rd[2:0], 32'h3);
      wdt_overflow <= 1'b1;
      @(posedge clk_sys);
      wdt_overflow <= 1'b0;
      count(3, 4, n);
      chk(n != 0, w[3:2] == 2'h1 || w[3:2] == 2'h2);
      // Tick rates per power mode; the settle lets each divider reach its steady phase.
      for (int pm = 0; pm < 4; pm++) begin
        power_mode <= code_option_pkg::power_mode_t'(pm);
        ef = (pm == 0) ? (256 >> w[10:8]) : (pm == 1) ? (64 >> w[12:11]) : 0;
        ew = (w[3:2] == 2'h2 || (w[3:2] == 2'h1 && pm < 2)) ? (8 >> wc) : 0;
        repeat (40) @(posedge clk_sys);
        count(0, 256, n);
        chk(n, ef);
        count(1, 256, n);
        chk(n, ew);
      end
      // Supply walks down through each threshold, then recovers.
      below <= 3'b100;
      repeat (6) @(posedge clk_sys);
      chk({brownout_reset, high_f, mid_f}, {lv == 2'h3, lv == 2'h2, 1'b0});
      below <= 3'b110;
      repeat (6) @(posedge clk_sys);
      chk({brownout_reset, high_f, mid_f}, {lv[1], lv == 2'h2, lv == 2'h1});
      below <= 3'b111;
      repeat (6) @(posedge clk_sys);
      chk(brownout_reset, 32'h1);
      apb(`REG_FLAGS, 1'b0, 32'h0, rd, er);
      chk(rd, {28'h0, lv == 2'h2, lv == 2'h1, 1'b1, 1'b0});
      below <= 3'b000;
      repeat (6) @(posedge clk_sys);
      chk({brownout_reset, high_f, mid_f}, 32'h0);
    end
    report_and_stop();
  end
endmodule
